// ### rtl/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define CKS_ADDR     16'hfff0
`define CKS_RESET    8'h00
`define CKS_EXT0     1
`define SEL_CMD      2'h3
`define SC_MSB       7
`define SC_LSB       6
`define RW_MSB       5
`define RW_LSB       4
`define CM_MSB       3
`define CM_LSB       1
`define BASE_BIT     0
`define SC_MULTI     2'h3
`define RW_LATCH     2'h0
`define RW_LOW       2'h1
`define RW_HIGH      2'h2
`define RW_BOTH      2'h3
`define ML_COUNT_N   5
`define ML_STATUS_N  4
`define ML_CT0       1
`define RD_UNDEF     8'h00
`endif

// ### rtl/timer_pkg.sv
package timer_pkg;
   typedef struct packed {
      logic [15:0] count;
      logic        outLevel;
   } down_state_s;

   typedef struct packed {
      logic [2:0][1:0]  rwMode;
      logic [2:0][2:0]  count_mode_field;
      logic [2:0]       bcd;
      logic [2:0][15:0] countReg;
      logic [2:0]       writeHigh;
      logic [2:0]       readHigh;
      logic [2:0][15:0] countLatch;
      logic [2:0]       countLatched;
      logic [2:0][7:0]  statusLatch;
      logic [2:0]       statusLatched;
      logic [2:0]       nullCount;
      logic [2:0]       countPending;
      logic [2:0]       modeWrite;
      logic [7:0]       clkSel;
      logic [7:0]       rdata;
   } unit_state_s;
endpackage

// ### rtl/timer_addr_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer_params.svh"
module timer_addr_decode (
   input  wire logic [15:0] ioAddr,
   input  wire logic [7:0]  baseHigh,
   input  wire logic [7:0]  baseLow,
   input  wire logic        gapOption,
   output logic             regHit,
   output logic [1:0]       regSel,
   output logic             cksHit
);
   always_comb begin
      cksHit = (ioAddr == `CKS_ADDR);
      if (gapOption) begin
         regHit = !cksHit && (ioAddr[15:8] == baseHigh) && (ioAddr[7:2] == baseLow[7:2]);
         regSel = ioAddr[1:0];
      end else begin
         // Bit 0 is ignored here, so each port shows at two addresses
         regHit = !cksHit && (ioAddr[15:8] == baseHigh) && (ioAddr[7:3] == baseLow[7:3]);
         regSel = ioAddr[2:1];
      end
   end
endmodule
`default_nettype wire

// ### rtl/timer_down_counter.sv
`timescale 1ns/1ns
`default_nettype none
module timer_down_counter (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        tick,
   input  wire logic        loadReq,
   input  wire logic [15:0] loadValue,
   input  wire logic        bcd,
   input  wire logic        modeWrite,
   output logic             loaded,
   output logic [15:0]      count,
   output logic             outLevel
);
   timer_pkg::down_state_s st_ff;
   timer_pkg::down_state_s nxt_st;

   function automatic logic [15:0] bcdDec(input logic [15:0] v);
      logic [15:0] r;
      logic        borrow;
      r      = v;
      borrow = 1'b1;
      for (int d = 0; d < 4; d++) begin
         if (borrow) begin
            if (v[d*4 +: 4] == 4'h0) begin
               r[d*4 +: 4] = 4'h9;
            end else begin
               r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
               borrow      = 1'b0;
            end
         end
      end
      return r;
   endfunction

   assign loaded = tick && loadReq;

   always_comb begin
      nxt_st = st_ff;
      if (modeWrite) begin
         nxt_st.outLevel = 1'b1;
      end else if (loaded) begin
         nxt_st.count    = loadValue;
         nxt_st.outLevel = 1'b1;
      end else if (tick) begin
         nxt_st.count = bcd ? bcdDec(st_ff.count) : st_ff.count - 16'h0001;
         if (st_ff.count == 16'h0001) begin
            nxt_st.outLevel = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count    = st_ff.count;
   assign outLevel = st_ff.outLevel;
endmodule
`default_nettype wire

// ### rtl/timer_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "timer_params.svh"
module timer_unit #(
   parameter int CHANNELS = 3
) (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] ioAddr,
   input  wire logic        ioWr,
   input  wire logic        ioRd,
   input  wire logic [7:0]  ioWdata,
   output logic [7:0]       ioRdata,
   input  wire logic [7:0]  baseHigh,
   input  wire logic [7:0]  baseLow,
   input  wire logic        gapOption,
   input  wire logic        intTick,
   input  wire logic [2:0]  extTick,
   output logic [2:0]       counterOut,
   output logic [7:0]       clockSource
);
   timer_pkg::unit_state_s st_ff;
   timer_pkg::unit_state_s nxt_st;

   logic             regHit;
   logic [1:0]       regSel;
   logic             cksHit;
   logic [2:0]       tick;
   logic [2:0]       loaded;
   logic [2:0][15:0] downCount;
   logic [2:0]       outLevel;

   timer_addr_decode u_decode (
      .ioAddr    (ioAddr),
      .baseHigh  (baseHigh),
      .baseLow   (baseLow),
      .gapOption (gapOption),
      .regHit    (regHit),
      .regSel    (regSel),
      .cksHit    (cksHit)
   );

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : gen_ch
         // Selector bit set picks the external tick for this channel
         assign tick[g] = st_ff.clkSel[`CKS_EXT0 + g] ? extTick[g] : intTick;

         timer_down_counter u_down (
            .ref_clk   (ref_clk),
            .reset_n   (reset_n),
            .tick      (tick[g]),
            .loadReq   (st_ff.countPending[g]),
            .loadValue (st_ff.countReg[g]),
            .bcd       (st_ff.bcd[g]),
            .modeWrite (st_ff.modeWrite[g]),
            .loaded    (loaded[g]),
            .count     (downCount[g]),
            .outLevel  (outLevel[g])
         );
      end
   endgenerate

   // Mode field with the don't-care top bit folded away
   function automatic logic [2:0] normMode(input logic [2:0] m);
      if (m[1]) begin
         return {1'b0, m[1:0]};
      end
      return m;
   endfunction

   always_comb begin
      logic [1:0]  ch;
      logic [1:0]  sc;
      logic [15:0] src;
      logic        release_;
      ch       = regSel;
      sc       = ioWdata[`SC_MSB:`SC_LSB];
      src      = 16'h0000;
      release_ = 1'b0;
      nxt_st   = st_ff;
      nxt_st.modeWrite = 3'b000;

      // transfer clears pending and null count; later writes win
      for (int i = 0; i < CHANNELS; i++) begin
         if (loaded[i]) begin
            nxt_st.countPending[i] = 1'b0;
            nxt_st.nullCount[i]    = 1'b0;
         end
      end

      if (ioWr) begin
         if (cksHit) begin
            nxt_st.clkSel = ioWdata;
         end else if (regHit && (ch != `SEL_CMD)) begin
            // data port of the addressed counter
            case (st_ff.rwMode[ch])
               `RW_LOW: begin
                  nxt_st.countReg[ch]     = {8'h00, ioWdata};
                  nxt_st.countPending[ch] = 1'b1;
                  nxt_st.nullCount[ch]    = 1'b1;
               end
               `RW_HIGH: begin
                  nxt_st.countReg[ch]     = {ioWdata, 8'h00};
                  nxt_st.countPending[ch] = 1'b1;
                  nxt_st.nullCount[ch]    = 1'b1;
               end
               `RW_BOTH: begin
                  if (!st_ff.writeHigh[ch]) begin
                     nxt_st.countReg[ch][7:0] = ioWdata;
                     nxt_st.writeHigh[ch]     = 1'b1;
                  end else begin
                     nxt_st.countReg[ch][15:8] = ioWdata;
                     nxt_st.writeHigh[ch]      = 1'b0;
                     nxt_st.countPending[ch]   = 1'b1;
                     nxt_st.nullCount[ch]      = 1'b1;
                  end
               end
               default: begin
                  // Unprogrammed counter: count writes are dropped
                  nxt_st.countReg[ch] = st_ff.countReg[ch];
               end
            endcase
         end else if (regHit) begin
            if (sc == `SC_MULTI) begin
               // bits 5 to 1 are latch controls
               for (int i = 0; i < CHANNELS; i++) begin
                  if (ioWdata[`ML_CT0 + i]) begin
                     if (!ioWdata[`ML_COUNT_N] && !st_ff.countLatched[i]) begin
                        nxt_st.countLatch[i]   = downCount[i];
                        nxt_st.countLatched[i] = 1'b1;
                     end
                     if (!ioWdata[`ML_STATUS_N] && !st_ff.statusLatched[i]) begin
                        nxt_st.statusLatch[i]   = {outLevel[i], st_ff.nullCount[i], st_ff.rwMode[i],
                                                   st_ff.count_mode_field[i], st_ff.bcd[i]};
                        nxt_st.statusLatched[i] = 1'b1;
                     end
                  end
               end
            // byte access zero is count latch
            end else if (ioWdata[`RW_MSB:`RW_LSB] == `RW_LATCH) begin
               if (!st_ff.countLatched[sc]) begin
                  nxt_st.countLatch[sc]   = downCount[sc];
                  nxt_st.countLatched[sc] = 1'b1;
               end
            end else begin
               nxt_st.rwMode[sc] = ioWdata[`RW_MSB:`RW_LSB];
               nxt_st.count_mode_field[sc]  = normMode(ioWdata[`CM_MSB:`CM_LSB]);
               nxt_st.bcd[sc]    = ioWdata[`BASE_BIT];
               nxt_st.countLatched[sc]  = 1'b0;
               nxt_st.statusLatched[sc] = 1'b0;
               nxt_st.writeHigh[sc]     = 1'b0;
               nxt_st.readHigh[sc]      = 1'b0;
               // old count dropped until a new one arrives
               nxt_st.countPending[sc]  = 1'b0;
               nxt_st.nullCount[sc]     = 1'b1;
               nxt_st.modeWrite[sc]     = 1'b1;
            end
         end
      end

      if (ioRd) begin
         if (cksHit) begin
            nxt_st.rdata = st_ff.clkSel;
         end else if (regHit && (ch == `SEL_CMD)) begin
            nxt_st.rdata = `RD_UNDEF;
         end else if (regHit) begin
            if (st_ff.statusLatched[ch]) begin
               nxt_st.rdata             = st_ff.statusLatch[ch];
               nxt_st.statusLatched[ch] = 1'b0;
            end else begin
               // Unlatched reads see a live counter and may tear
               src = st_ff.countLatched[ch] ? st_ff.countLatch[ch] : downCount[ch];
               case (st_ff.rwMode[ch])
                  `RW_HIGH: begin
                     nxt_st.rdata = src[15:8];
                     release_     = 1'b1;
                  end
                  `RW_BOTH: begin
                     if (!st_ff.readHigh[ch]) begin
                        nxt_st.rdata        = src[7:0];
                        nxt_st.readHigh[ch] = 1'b1;
                     end else begin
                        nxt_st.rdata        = src[15:8];
                        nxt_st.readHigh[ch] = 1'b0;
                        release_            = 1'b1;
                     end
                  end
                  default: begin
                     nxt_st.rdata = src[7:0];
                     release_     = 1'b1;
                  end
               endcase
               // latch released by read
               // A latch command in this same cycle is dropped while a latch is held, so the release still clears it
               if (release_ && st_ff.countLatched[ch]) begin
                  nxt_st.countLatched[ch] = 1'b0;
               end
            end
         end else begin
            nxt_st.rdata = `RD_UNDEF;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         st_ff        <= '0;
         st_ff.clkSel <= `CKS_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ioRdata     = st_ff.rdata;
   assign counterOut  = outLevel;
   assign clockSource = st_ff.clkSel;
endmodule
`default_nettype wire

// ### verif/timer_unit_chk.sv
`timescale 1ns/1ns
`default_nettype none
module timer_unit_chk #(
   parameter int CHANNELS = 3
) (
   input wire logic        ref_clk,
   input wire logic        reset_n,
   input wire logic [15:0] ioAddr,
   input wire logic        ioWr,
   input wire logic        ioRd,
   input wire logic [7:0]  ioWdata,
   input wire logic [7:0]  ioRdata,
   input wire logic [7:0]  baseHigh,
   input wire logic [7:0]  baseLow,
   input wire logic        gapOption,
   input wire logic        intTick,
   input wire logic [2:0]  extTick,
   input wire logic [2:0]  counterOut,
   input wire logic [7:0]  clockSource
);
   logic       isCks;
   logic       hit;
   logic [1:0] sel;
   logic       cmdWr;
   logic       tick0;
   logic [5:0] mode0_ff;
   assign isCks = ioAddr == 16'hfff0;
   assign sel   = gapOption ? ioAddr[1:0] : ioAddr[2:1];
   assign hit   = !isCks && ioAddr[15:8] == baseHigh
                  && (gapOption ? ioAddr[7:2] == baseLow[7:2] : ioAddr[7:3] == baseLow[7:3]);
   assign cmdWr = ioWr && hit && sel == 2'h3;
   assign tick0 = clockSource[1] ? extTick[0] : intTick;
   // Status echoes the mode word; a set middle mode bit drops the top one
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         mode0_ff <= 6'h00;
      end else if (cmdWr && ioWdata[7:6] == 2'h0 && ioWdata[5:4] != 2'h0) begin
         mode0_ff <= {ioWdata[5:3] & {2'h3, !ioWdata[2]}, ioWdata[2:0]};
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence stLatch0;
      cmdWr && ioWdata[7:6] == 2'h3 && !ioWdata[4] && ioWdata[1];
   endsequence
   sequence rd0;
      ioRd && !ioWr && hit && sel == 2'h0;
   endsequence
   cks_write_a: assert property (ioWr && isCks |=> clockSource == $past(ioWdata))
      else $error("clock select write lost");
   cks_read_a: assert property (ioRd && !ioWr && isCks |=> ioRdata == $past(clockSource))
      else $error("clock select read wrong");
   cks_hold_a: assert property (!(ioWr && isCks) |=> $stable(clockSource))
      else $error("clock select changed without write");
   rdata_hold_a: assert property (!ioRd |=> $stable(ioRdata))
      else $error("read data changed without read");
   miss_read_a: assert property (ioRd && !ioWr && !isCks && (!hit || sel == 2'h3) |=> ioRdata == 8'h00)
      else $error("unmapped or command read not zero");
   mode_out_a: assert property (cmdWr && ioWdata[7:6] == 2'h0 && ioWdata[5:4] != 2'h0 |=> ##1 counterOut[0])
      else $error("mode write left output low");
   out_fall_a: assert property ($fell(counterOut[0]) |-> $past(tick0))
      else $error("output fell without a tick");
   status_first_a: assert property (stLatch0 ##[1:2] rd0 |=> ioRdata[5:0] == mode0_ff)
      else $error("first read after status latch not status");
endmodule
bind timer_unit timer_unit_chk #(.CHANNELS(CHANNELS)) u_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
   .ioWdata(ioWdata), .ioRdata(ioRdata), .baseHigh(baseHigh), .baseLow(baseLow),
   .gapOption(gapOption), .intTick(intTick), .extTick(extTick), .counterOut(counterOut),
   .clockSource(clockSource)
);
`default_nettype wire

// ### verif/timer_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module timer_host_model (
   input  wire logic        ref_clk,
   output logic [15:0]      ioAddr,
   output logic             ioWr,
   output logic             ioRd,
   output logic [7:0]       ioWdata,
   input  wire logic [7:0]  ioRdata
);
   initial begin
      ioAddr  = 16'h0000;
      ioWr    = 1'b0;
      ioRd    = 1'b0;
      ioWdata = 8'h00;
   end
   // Released bus shows inverted values so stale data never looks valid
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      ioAddr  <= a;
      ioWdata <= d;
      ioWr    <= 1'b1;
      @(posedge ref_clk);
      ioWr    <= 1'b0;
      ioAddr  <= ~a;
      ioWdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      ioAddr <= a;
      ioRd   <= 1'b1;
      @(posedge ref_clk);
      ioRd   <= 1'b0;
      ioAddr <= ~a;
      // Read data stands until the next read, so it is taken at the following edge
      @(posedge ref_clk);
      d = ioRdata;
   endtask
endmodule
`default_nettype wire

// ### verif/timer_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module timer_unit_tb;
   logic        ref_clk = 1'b0;
   logic        reset_n;
   logic [15:0] ioAddr;
   logic        ioWr;
   logic        ioRd;
   logic [7:0]  ioWdata;
   logic [7:0]  ioRdata;
   logic [7:0]  baseHigh;
   logic [7:0]  baseLow;
   logic        gapOption;
   logic        intTick;
   logic [2:0]  extTick;
   logic [2:0]  counterOut;
   logic [7:0]  clockSource;
   int          badCount = 0;
   int          numChecks = 0;
   timer_unit u_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
      .ioWdata(ioWdata), .ioRdata(ioRdata), .baseHigh(baseHigh), .baseLow(baseLow),
      .gapOption(gapOption), .intTick(intTick), .extTick(extTick), .counterOut(counterOut),
      .clockSource(clockSource)
   );
   timer_host_model u_host (
      .ref_clk(ref_clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWdata(ioWdata), .ioRdata(ioRdata)
   );
   always #4 ref_clk = ~ref_clk;
   function automatic logic [15:0] a1(input logic [1:0] s);
      return {8'h12, 6'h10, s};
   endfunction
   // A0 is set on purpose: it must be ignored with gap option 0
   function automatic logic [15:0] a0(input logic [1:0] s);
      return {8'h12, 5'h08, s, 1'b1};
   endfunction
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      numChecks++;
      if (s !== e) begin
         badCount++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] e, input string n);
      logic [7:0] d;
      u_host.rd(a, d);
      check(n, d, e);
   endtask
   task automatic pulse(input int ch, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         if (ch == 0) extTick <= 3'h1;
         else intTick <= 1'b1;
         @(posedge ref_clk);
         extTick <= 3'h0;
         intTick <= 1'b0;
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      badCount++;
      results();
   end
   initial begin
      reset_n = 1'b0;
      gapOption = 1'b1;
      intTick = 1'b0;
      extTick = 3'h0;
      baseHigh = 8'h12;
      baseLow = 8'h40;
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
      check("clockSource", clockSource, 8'h00);
      u_host.wr(16'hfff0, 8'h02);
      rc(16'hfff0, 8'h02, "cks");
      u_host.wr(16'hfff1, 8'hff);
      rc(16'hfff0, 8'h02, "cks kept");
      u_host.wr(a1(2'h3), 8'h34);
      u_host.wr(a1(2'h0), 8'h05);
      u_host.wr(a1(2'h0), 8'h00);
      pulse(0, 1);
      u_host.wr(a1(2'h3), 8'h00);
      pulse(0, 1);
      u_host.wr(a1(2'h3), 8'h00);
      rc(a1(2'h0), 8'h05, "latch lo");
      rc(a1(2'h0), 8'h00, "latch hi");
      rc(a1(2'h0), 8'h04, "direct lo");
      rc(a1(2'h0), 8'h00, "direct hi");
      u_host.wr(a1(2'h3), 8'hc2);
      rc(a1(2'h0), 8'hb4, "status");
      rc(a1(2'h0), 8'h04, "ml lo");
      rc(a1(2'h0), 8'h00, "ml hi");
      rc(a1(2'h3), 8'h00, "cmd read");
      rc(16'h0000, 8'h00, "unmapped");
      u_host.wr(a1(2'h3), 8'h3c);
      u_host.wr(a1(2'h3), 8'hc2);
      rc(a1(2'h0), 8'hf4, "status m6");
      u_host.wr(a1(2'h3), 8'h34);
      u_host.wr(a1(2'h0), 8'h07);
      u_host.wr(a1(2'h3), 8'h34);
      u_host.wr(a1(2'h0), 8'h09);
      u_host.wr(a1(2'h0), 8'h00);
      pulse(0, 1);
      u_host.wr(a1(2'h3), 8'h00);
      rc(a1(2'h0), 8'h09, "reseq lo");
      rc(a1(2'h0), 8'h00, "reseq hi");
      pulse(0, 8);
      @(negedge ref_clk);
      check("out0 high", {7'h00, counterOut[0]}, 8'h01);
      pulse(0, 1);
      @(negedge ref_clk);
      check("out0 low", {7'h00, counterOut[0]}, 8'h00);
      @(posedge ref_clk);
      gapOption <= 1'b0;
      rc(16'hfff0, 8'h02, "cks gap0");
      u_host.wr(a0(2'h3), 8'h61);
      u_host.wr(a0(2'h1), 8'h10);
      pulse(1, 2);
      u_host.wr(a0(2'h3), 8'h40);
      rc(a0(2'h1), 8'h09, "bcd hi");
      u_host.wr(a0(2'h3), 8'h90);
      u_host.wr(a0(2'h2), 8'h33);
      pulse(1, 1);
      u_host.wr(a0(2'h3), 8'h80);
      rc(a0(2'h2), 8'h33, "ch2 lo");
      rc(a0(2'h3), 8'h00, "cmd gap0");
      @(negedge ref_clk);
      check("counterOut", {5'h00, counterOut}, 8'h06);
      results();
   end
endmodule
`default_nettype wire
